// ### bsiu_cfg.svh
// constants for the bit-serial interrupt and i/o unit
`ifndef BSIU_CFG_SVH
`define BSIU_CFG_SVH
`define BSIU_NUM_IRQ 15
`define BSIU_NUM_DED_IRQ 6
`define BSIU_NUM_SHARED 9
`define BSIU_NUM_DED_PORT 7
`define BSIU_NUM_PORT 16
`define BSIU_CLK_BITS 14
`define BSIU_SYNC_W 31
`define BSIU_SEL_CONTROL 5'h00
`define BSIU_SEL_LAST_CLK 5'h0e
`define BSIU_SEL_SOFT_RST 5'h0f
`define BSIU_PORT_SEL_BIT 4
`define BSIU_CODE_NONE 4'hf
`define BSIU_CODE_RESET 4'h0
`define BSIU_SYNC_INIT {1'b0, 1'b1, 1'b0, 1'b0, 5'h00, 7'h00, 9'h1ff, 6'h3f}
`endif

// ### bsiu_host.sv
// host processor model driving the bit-serial i/o bus
`timescale 1ns/1ps
`default_nettype none
module bsiu_host
	import bsiu_pkg::*;
(
	input wire logic clock,
	output var bsiu_pkg::bsiu_sel_t bit_select,
	output logic chip_select_n,
	output logic serial_write_bit,
	output logic write_strobe,
	input wire logic serial_read_bit_out,
	input wire logic serial_read_bit_oe
);
	initial
	begin
		{chip_select_n, bit_select, serial_write_bit, write_strobe} = 8'h80;
	end
	// released lines flip so a stale level cannot pass for an answer
	task automatic drop();
		chip_select_n <= 1'b1;
		bit_select <= ~bit_select;
		serial_write_bit <= ~serial_write_bit;
		@(posedge clock);
	endtask
	// cs_n high gives a strobe the unit must ignore
	task automatic wr(input bsiu_sel_t sel, input logic val, input logic cs_n);
		chip_select_n <= cs_n;
		bit_select <= sel;
		serial_write_bit <= val;
		repeat (4) @(posedge clock);
		write_strobe <= 1'b1;
		repeat (5) @(posedge clock);
		write_strobe <= 1'b0;
		repeat (6) @(posedge clock);
		drop();
	endtask
	task automatic rd(input bsiu_sel_t sel, output logic val, output logic oe);
		chip_select_n <= 1'b0;
		bit_select <= sel;
		repeat (4) @(posedge clock);
		// a released line shows the inverse, never a stale answer
		val = serial_read_bit_oe ? serial_read_bit_out : ~serial_read_bit_out;
		oe = serial_read_bit_oe;
		drop();
	endtask
endmodule
`default_nettype wire

// ### bsiu_pkg.sv
// types shared by the bit-serial interrupt and i/o unit
package bsiu_pkg;
	typedef logic [4:0] bsiu_sel_t;
	typedef logic [0:3] bsiu_code_t;
	typedef logic [5:0] bsiu_ded_irq_t;
	typedef logic [8:0] bsiu_shared_t;
	typedef logic [6:0] bsiu_ded_port_t;
endpackage

// ### bsiu_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module bsiu_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			meta <= INIT;
			q <= INIT;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// ### bsiu_top.sv
// bit-serial interrupt and i/o unit: masking, priority encoding, ports
// Notes on behaviour
// - request low while any enabled interrupt active, high once all removed
// - code shows highest enabled active interrupt, bit 0 most significant
// - no enabled active interrupt drives all four code lines high; power-up reset drives them all low
// - bus transfers only while selected; interrupt logic ignores select
// - read line carries selected bit, released whenever not selected
// - when selected, strobe writes data bit into addressed command bit
// - power-up reset clears masks, stops timer, makes every port input
// - six dedicated pins active low, masked individually, first highest priority
// - nine shared pins each usable as interrupt, input or output
// - seven dedicated port pins are input or output, never interrupts
// - code equals priority number, one highest to fifteen lowest
// - request and code updated on a system clock edge, registered
// - port write makes port output and latches value until reset
// - writing zero to select 15 in clock mode returns ports to input
`timescale 1ns/1ps
`default_nettype none
`include "bsiu_cfg.svh"
module bsiu_top (
	input wire logic clock,
	input wire logic rst,
	input wire logic power_up_reset_n,
	input wire logic chip_select_n,
	input wire bsiu_pkg::bsiu_sel_t bit_select,
	input wire logic serial_write_bit,
	input wire logic write_strobe,
	output logic serial_read_bit_out,
	output logic serial_read_bit_oe,
	output logic interrupt_request_n,
	output bsiu_pkg::bsiu_code_t priority_code,
	input wire bsiu_pkg::bsiu_ded_irq_t dedicated_irq_pins,
	input wire bsiu_pkg::bsiu_shared_t shared_irq_port_pins_in,
	output logic [8:0] shared_irq_port_pins_out,
	output logic [8:0] shared_irq_port_pins_oe,
	input wire bsiu_pkg::bsiu_ded_port_t dedicated_port_pins_in,
	output logic [6:0] dedicated_port_pins_out,
	output logic [6:0] dedicated_port_pins_oe,
	output logic timer_enabled
);
	import bsiu_pkg::*;

	logic [`BSIU_SYNC_W-1:0] sync_q;
	logic por_s;
	logic cs_s;
	logic strobe_s;
	logic wbit_s;
	bsiu_sel_t sel_s;
	bsiu_ded_port_t dport_s;
	bsiu_shared_t shared_s;
	bsiu_ded_irq_t ded_s;
	logic strobe_d;
	logic strobe_rise;
	logic wr;
	logic [3:0] idx;
	logic ctrl_mode;
	logic [`BSIU_NUM_IRQ-1:0] mask;
	logic [`BSIU_CLK_BITS-1:0] clk_start;
	logic [`BSIU_NUM_PORT-1:0] port_dir;
	logic [`BSIU_NUM_PORT-1:0] port_out;
	logic [`BSIU_NUM_PORT-1:0] pin_lvl;
	logic [`BSIU_NUM_IRQ-1:0] irq_lvl;
	logic [`BSIU_NUM_IRQ-1:0] active;
	logic [3:0] next_code;
	logic soft_rst;
	logic next_rd;
	bsiu_sel_t last_sel;
	logic last_wbit;

	// every pin, strobe and select is foreign to this clock
	bsiu_sync #(.W(`BSIU_SYNC_W), .INIT(`BSIU_SYNC_INIT)) u_sync (
		.clock(clock),
		.rst(rst),
		.d({power_up_reset_n, chip_select_n, write_strobe, serial_write_bit, bit_select,
			dedicated_port_pins_in, shared_irq_port_pins_in, dedicated_irq_pins}),
		.q(sync_q)
	);

	assign {por_s, cs_s, strobe_s, wbit_s, sel_s, dport_s, shared_s, ded_s} = sync_q;
	assign irq_lvl = {shared_s, ded_s};
	assign idx = sel_s[3:0] - 4'h1;
	assign strobe_rise = strobe_s & ~strobe_d;
	// select and data settle long before the strobe, so the synced copies agree
	assign wr = strobe_rise & ~cs_s & por_s;
	assign soft_rst = wr & ctrl_mode & (sel_s == `BSIU_SEL_SOFT_RST) & ~wbit_s;

	// shared pin k is interrupt 7+k and port 15-k
	always_comb
	begin
		pin_lvl[6:0] = dport_s;
		for (int p = `BSIU_NUM_DED_PORT; p < `BSIU_NUM_PORT; p++)
			pin_lvl[p] = shared_s[`BSIU_NUM_PORT-1-p];
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			strobe_d <= 1'b0;
			last_sel <= 5'h00;
			last_wbit <= 1'b0;
		end
		else
		begin
			strobe_d <= strobe_s;
			last_sel <= sel_s;
			last_wbit <= wbit_s;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			ctrl_mode <= 1'b0;
		else if (wr && sel_s == `BSIU_SEL_CONTROL)
			ctrl_mode <= wbit_s;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			mask <= 15'h0000;
		else if (!por_s)
			mask <= 15'h0000;
		else if (wr && !ctrl_mode && !sel_s[`BSIU_PORT_SEL_BIT] && sel_s != `BSIU_SEL_CONTROL)
			mask[idx] <= wbit_s;
	end

	// timer itself is not built; its start value only gates the enable flag
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			clk_start <= 14'h0000;
		else if (!por_s)
			clk_start <= 14'h0000;
		else if (wr && ctrl_mode && sel_s != `BSIU_SEL_CONTROL && sel_s <= `BSIU_SEL_LAST_CLK)
			clk_start[idx] <= wbit_s;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			timer_enabled <= 1'b0;
		else
			timer_enabled <= por_s & (|clk_start);
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			port_dir <= 16'h0000;
			port_out <= 16'h0000;
		end
		else if (!por_s || soft_rst)
			port_dir <= 16'h0000;
		else if (wr && sel_s[`BSIU_PORT_SEL_BIT])
		begin
			port_dir[sel_s[3:0]] <= 1'b1;
			port_out[sel_s[3:0]] <= wbit_s;
		end
	end

	assign dedicated_port_pins_out = port_out[6:0];
	assign dedicated_port_pins_oe = port_dir[6:0];
	generate
		for (genvar k = 0; k < `BSIU_NUM_SHARED; k++)
		begin : g_shared
			assign shared_irq_port_pins_out[k] = port_out[`BSIU_NUM_PORT-1-k];
			assign shared_irq_port_pins_oe[k] = port_dir[`BSIU_NUM_PORT-1-k];
		end
	endgenerate

	// interrupt path never looks at the select line
	assign active = ~irq_lvl & mask;

	always_comb
	begin
		next_code = `BSIU_CODE_NONE;
		for (int i = `BSIU_NUM_IRQ-1; i >= 0; i--)
			if (active[i])
				next_code = 4'(i + 1);
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			interrupt_request_n <= 1'b1;
			priority_code <= `BSIU_CODE_RESET;
		end
		else if (!por_s)
		begin
			interrupt_request_n <= 1'b1;
			priority_code <= `BSIU_CODE_RESET;
		end
		else
		begin
			interrupt_request_n <= ~(|active);
			priority_code <= next_code;
		end
	end

	// interrupt inputs read back raw pin level regardless of mask
	always_comb
	begin
		if (sel_s == `BSIU_SEL_CONTROL)
			next_rd = ctrl_mode;
		else if (sel_s[`BSIU_PORT_SEL_BIT])
			next_rd = pin_lvl[sel_s[3:0]];
		else if (!ctrl_mode)
			next_rd = irq_lvl[idx];
		else if (sel_s == `BSIU_SEL_SOFT_RST)
			next_rd = interrupt_request_n;
		else
			next_rd = clk_start[idx];
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			serial_read_bit_out <= 1'b0;
			serial_read_bit_oe <= 1'b0;
		end
		else
		begin
			serial_read_bit_out <= next_rd;
			serial_read_bit_oe <= ~cs_s;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_port_wr;
		wr && sel_s[`BSIU_PORT_SEL_BIT];
	endsequence

	sequence s_soft;
		soft_rst;
	endsequence

	sequence s_mask1_wr;
		wr && !ctrl_mode && sel_s == 5'h01;
	endsequence

	a_req_on_active: assert property (por_s && (|active) |=> !interrupt_request_n)
		else $error("request not low with enabled active interrupt");
	a_idle_all_high: assert property (por_s && !(|active) |=> interrupt_request_n && priority_code == 4'hf)
		else $error("idle outputs not all high");
	a_code_top_prio: assert property (por_s && active[0] |=> priority_code == 4'h1)
		else $error("highest interrupt not coded as one");
	a_code_lowest: assert property (por_s && active == 15'h4000 |=> priority_code == 4'hf && !interrupt_request_n)
		else $error("lowest interrupt code wrong");
	a_read_release: assert property (cs_s |=> !serial_read_bit_oe)
		else $error("read line driven while deselected");
	a_por_clears: assert property (!por_s |=> mask == 15'h0000 && port_dir == 16'h0000 ##1 !timer_enabled)
		else $error("power-up reset did not clear state");
	a_ignore_desel: assert property (strobe_rise && cs_s |=> $stable(mask) && $stable(port_dir) && $stable(ctrl_mode))
		else $error("write taken while deselected");
	a_port_write: assert property (s_port_wr |=> port_dir[last_sel[3:0]] && port_out[last_sel[3:0]] == last_wbit)
		else $error("port write did not latch output");
	a_soft_reset: assert property (s_soft |=> port_dir == 16'h0000)
		else $error("soft port reset did not clear directions");
	a_mask_write: assert property (s_mask1_wr |=> mask[0] == last_wbit)
		else $error("mask write not stored");
endmodule
`default_nettype wire

// ### bsiu_top_tb.sv
// self-checking bench for the bit-serial interrupt and i/o unit
`timescale 1ns/1ps
`default_nettype none
module bsiu_top_tb;
	import bsiu_pkg::*;
	logic clock, rst, power_up_reset_n, serial_read_bit_out, serial_read_bit_oe, interrupt_request_n, timer_enabled;
	logic chip_select_n, serial_write_bit, write_strobe, v, rv, roe;
	bsiu_sel_t bit_select;
	bsiu_code_t priority_code;
	bsiu_ded_irq_t dedicated_irq_pins;
	logic [8:0] sh_drv, sh_out, sh_oe;
	logic [6:0] dp_drv, dp_out, dp_oe;
	logic [15:1] mask;
	logic [15:0] pdir, pval;
	int seed, check_count, mismatches, p;
	logic [4:0] e;
	// pin level seen by everyone: the unit when it drives, the bench otherwise
	wire [8:0] sh_in = (sh_oe & sh_out) | (~sh_oe & sh_drv);
	wire [6:0] dp_in = (dp_oe & dp_out) | (~dp_oe & dp_drv);
	bsiu_top u_dut (.clock, .rst, .power_up_reset_n, .chip_select_n, .bit_select, .serial_write_bit, .write_strobe,
		.serial_read_bit_out, .serial_read_bit_oe, .interrupt_request_n, .priority_code, .dedicated_irq_pins,
		.shared_irq_port_pins_in(sh_in), .shared_irq_port_pins_out(sh_out), .shared_irq_port_pins_oe(sh_oe),
		.dedicated_port_pins_in(dp_in), .dedicated_port_pins_out(dp_out), .dedicated_port_pins_oe(dp_oe), .timer_enabled);
	bsiu_host u_host (.clock, .bit_select, .chip_select_n, .serial_write_bit, .write_strobe, .serial_read_bit_out,
		.serial_read_bit_oe);
	function automatic logic pin_lvl(input int i);
		return (i <= 6) ? dedicated_irq_pins[i-1] : sh_in[i-7];
	endfunction
	// request in bit 4, priority number below; lowest index wins
	function automatic logic [4:0] exp_irq();
		for (int i = 1; i <= 15; i++)
			if (mask[i] && !pin_lvl(i))
				return {1'b0, 4'(i)};
		return 5'h1f;
	endfunction
	function automatic logic [15:0] port_vec(input logic [6:0] d, input logic [8:0] s);
		port_vec[6:0] = d;
		for (int k = 0; k < 9; k++)
			port_vec[15-k] = s[k];
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] time %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_irq();
		chk({interrupt_request_n, priority_code}, exp_irq());
	endtask
	task automatic chk_ports();
		chk(port_vec(dp_oe, sh_oe), pdir);
		chk(port_vec(dp_out, sh_out) & pdir, pval & pdir);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial
	begin
		#200000;
		mismatches++;
		finish_test();
	end
	initial
	begin
		seed = $urandom(63);
		{rst, power_up_reset_n, dedicated_irq_pins, sh_drv, dp_drv, mask, pdir, pval} = {2'b10, 69'h0};
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		repeat (5) @(posedge clock);
		chk({interrupt_request_n, priority_code}, 5'h10);
		power_up_reset_n <= 1'b1;
		repeat (5) @(posedge clock);
		chk_irq();
		chk_ports();
		$display("reset test done");
		for (int i = 1; i <= 15; i++)
		begin
			v = 1'($urandom);
			u_host.wr(5'(i), v, 1'b0);
			mask[i] = v;
		end
		for (int n = 0; n < 40; n++)
		begin
			{sh_drv, dedicated_irq_pins} <= 15'($urandom | $urandom);
			repeat (5) @(posedge clock);
			chk_irq();
			p = 1 + $urandom % 15;
			u_host.rd(5'(p), rv, roe);
			chk({roe, rv}, {1'b1, pin_lvl(p)});
			repeat (4) @(posedge clock);
			chk(serial_read_bit_oe, 1'b0);
		end
		u_host.wr(5'h0f, 1'b1, 1'b0);
		mask[15] = 1'b1;
		{sh_drv, dedicated_irq_pins} <= 15'h3fff;
		repeat (5) @(posedge clock);
		chk_irq();
		u_host.wr(5'h01, ~mask[1], 1'b1);
		{sh_drv, dedicated_irq_pins} <= '0;
		repeat (5) @(posedge clock);
		chk_irq();
		$display("interrupt test done");
		for (int n = 0; n < 12; n++)
		begin
			p = $urandom % 16;
			v = 1'($urandom);
			u_host.wr(5'(16 + p), v, 1'b0);
			pdir[p] = 1'b1;
			pval[p] = v;
			chk_ports();
			u_host.rd(5'(16 + p), rv, roe);
			chk({roe, rv}, {1'b1, v});
		end
		u_host.wr(5'h00, 1'b1, 1'b0);
		u_host.wr(5'h05, 1'b1, 1'b0);
		chk(timer_enabled, 1'b1);
		u_host.rd(5'h05, rv, roe);
		chk({roe, rv}, {1'b1, 1'b1});
		u_host.rd(5'h00, rv, roe);
		chk({roe, rv}, {1'b1, 1'b1});
		e = exp_irq();
		u_host.rd(5'h0f, rv, roe);
		chk({roe, rv}, {1'b1, e[4]});
		u_host.wr(5'h0f, 1'b1, 1'b0);
		chk_ports();
		u_host.wr(5'h0f, 1'b0, 1'b0);
		pdir = '0;
		chk_ports();
		u_host.wr(5'h00, 1'b0, 1'b0);
		chk_irq();
		$display("port test done");
		u_host.wr(5'h10, 1'b1, 1'b0);
		pdir[0] = 1'b1;
		pval[0] = 1'b1;
		chk_ports();
		power_up_reset_n <= 1'b0;
		repeat (5) @(posedge clock);
		chk({interrupt_request_n, priority_code}, 5'h10);
		power_up_reset_n <= 1'b1;
		repeat (5) @(posedge clock);
		mask = '0;
		pdir = '0;
		chk_irq();
		chk_ports();
		chk(timer_enabled, 1'b0);
		$display("power-up reset test done");
		finish_test();
	end
endmodule
`default_nettype wire
